// ---- design/clkgen_pkg.sv ----
// Shared constants and types for the clock generator lock-event block.
// Assumes a single 200 MHz bus clock and a 32-bit AXI4-Lite register bus.
package clkgen_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTL = 8'h00;
    localparam logic [7:0] OFS_BW = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    // loop_control_register field positions
    localparam int CTL_IRQ_EN_BIT = 7;
    localparam int CTL_FLAG_BIT = 6;
    localparam int CTL_POWER_BIT = 5;
    localparam int CTL_SELECT_BIT = 4;
    // loop_bandwidth_register field positions
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    localparam int BW_ACQ_BIT = 5;
    // Interrupt status, clear and enable share this layout
    localparam int IRQ_LOOP_BIT = 0;
    // Reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] BW_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Low-power state of the device
    typedef enum logic [2:0] {
        MODE_RUN = 3'b001,
        MODE_WAIT = 3'b010,
        MODE_STOP = 3'b100
    } power_mode_t;

    // Decoded register select
    typedef enum logic [2:0] {
        SEL_NONE, SEL_CTL, SEL_BW, SEL_STAT, SEL_CLR, SEL_EN
    } reg_sel_t;

    // One register write as handed from the bus slave
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } reg_wr_t;

    // Pins sampled from outside the clock domain
    typedef struct packed {
        logic lock;
        logic vco;
        logic xtal;
    } pin_sample_t;
endpackage

// ---- design/pin_sync.sv ----
// Two-flop synchroniser for the pins from the analog clock generator.
// Assumes the inputs are asynchronous to aclk.
`timescale 1ns/1ps
module pin_sync
    import clkgen_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire pin_sample_t pins,
    output pin_sample_t pins_sync
);
    pin_sample_t stage1;

    // First stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            pins_sync <= '0;
        end else begin
            stage1 <= pins;
            pins_sync <= stage1;
        end
    end
endmodule

// ---- design/axil_regs.sv ----
// AXI4-Lite slave front end: turns bus transfers into write/read strobes.
// Assumes the register file answers rd_data/rd_ok/wr_ok combinationally.
`timescale 1ns/1ps
module axil_regs
    import clkgen_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output reg_wr_t wr,
    output logic wr_fire,
    input wire logic wr_ok,
    output logic [7:0] rd_addr,
    output logic rd_fire,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_full;
    logic w_full;

    // Address and data may arrive in either order
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign wr_fire = aw_full && w_full && !s_axi_bvalid;

    // Write channel holding registers and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            wr <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                wr.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                wr.data <= s_axi_wdata;
                wr.strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read is taken and answered on the next edge
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= RDATA_RESET;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ---- design/clkgen_lock_ctl.sv ----
// Clock generator control: loop power, base clock select, lock event
// flag and interrupt, low-power mode handling and break protection.
// Assumes the lock and clock pins come from the analog loop and
// oscillator, and the mode and break signals from core logic on aclk.
`timescale 1ns/1ps

// Function
// - Auto mode: flag set on every lock change
// - Interrupt request only with enable bit set
// - Flag sets regardless of enable bit
// - Manual mode: no interrupts, flag reads zero
// - Loop clock select accepted without lock check
// - Wait leaves oscillator, loop, selection unchanged
// - Stop without keep: all off, outputs low
// - Stop with keep: loop off, oscillator runs
// - Break clear with enable stays cleared afterwards
// - Protected break: accesses leave flag alone
// - Bandwidth mode bit: one auto, reset clears
// - Lock bit read-only in auto, zero manual
// - Core clock is selected source halved
// - Power-off and select guarded against each other
module clkgen_lock_ctl
    import clkgen_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic lock_detect,
    input wire logic vco_clock,
    input wire logic crystal_clock_in,
    input wire logic wait_instr,
    input wire logic stop_instr,
    input wire logic wake_event,
    input wire logic break_state,
    input wire logic break_flag_clear_enable,
    input wire logic osc_keep_in_sleep,
    output logic osc_enable,
    output logic loop_enable,
    output logic crystal_clock,
    output logic core_clock_output,
    output logic clockgen_interrupt_line
);
    // Decode a byte address into a register select
    function automatic reg_sel_t sel_of(input logic [7:0] addr);
        case (addr)
            OFS_CTL: sel_of = SEL_CTL;
            OFS_BW: sel_of = SEL_BW;
            OFS_IRQ_STAT: sel_of = SEL_STAT;
            OFS_IRQ_CLR: sel_of = SEL_CLR;
            OFS_IRQ_EN: sel_of = SEL_EN;
            default: sel_of = SEL_NONE;
        endcase
    endfunction

    reg_wr_t wr;
    logic wr_fire;
    logic wr_ok;
    logic [7:0] rd_addr;
    logic rd_fire;
    logic [31:0] rd_data;
    logic rd_ok;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    logic wr_lane;
    pin_sample_t pins_sync;
    logic loop_irq_enable;
    logic loop_irq_flag;
    logic loop_power_on;
    logic base_clock_select;
    logic auto_bw;
    logic acq_manual;
    power_mode_t mode;
    power_mode_t next_mode;
    logic in_stop;
    logic osc_running;
    logic loop_running;
    logic lock_seen;
    logic lock_prev;
    logic lock_change;
    logic vco_prev;
    logic xtal_prev;
    logic core_tick;
    logic flag_clear_ok;
    logic flag_clear;
    logic [7:0] ctl_view;
    logic [7:0] bw_view;
    logic flag_view;

    axil_regs axil_regs_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr(wr),
        .wr_fire(wr_fire),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_fire(rd_fire),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    pin_sync pin_sync_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins('{lock: lock_detect, vco: vco_clock, xtal: crystal_clock_in}),
        .pins_sync(pins_sync)
    );

    // Bus decode; only the low byte lane carries register bits
    assign wr_sel = sel_of(wr.addr);
    assign rd_sel = sel_of(rd_addr);
    assign wr_ok = (wr_sel != SEL_NONE);
    assign rd_ok = (rd_sel != SEL_NONE);
    assign wr_lane = wr_fire && wr.strb[0];

    // Power state
    assign in_stop = (mode == MODE_STOP);
    assign osc_running = !in_stop || osc_keep_in_sleep;
    assign loop_running = loop_power_on && !in_stop;
    assign osc_enable = osc_running;
    assign loop_enable = loop_running;

    // Mode transitions; wait touches no clock control
    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_RUN: begin
                if (stop_instr) begin
                    next_mode = MODE_STOP;
                end else if (wait_instr) begin
                    next_mode = MODE_WAIT;
                end
            end
            MODE_WAIT: begin
                if (wake_event) begin
                    next_mode = MODE_RUN;
                end
            end
            MODE_STOP: begin
                if (wake_event) begin
                    next_mode = MODE_RUN;
                end
            end
            default: next_mode = MODE_RUN;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= MODE_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // Loop power and base clock select, each guarding the other
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_power_on <= CTL_RESET[CTL_POWER_BIT];
            base_clock_select <= CTL_RESET[CTL_SELECT_BIT];
        end else if (wr_lane && wr_sel == SEL_CTL) begin
            loop_power_on <= wr.data[CTL_POWER_BIT] || base_clock_select;
            base_clock_select <= wr.data[CTL_SELECT_BIT] && loop_power_on;
        end
    end

    // Interrupt enable, reachable from control and enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_irq_enable <= CTL_RESET[CTL_IRQ_EN_BIT];
        end else if (wr_lane && wr_sel == SEL_CTL) begin
            loop_irq_enable <= wr.data[CTL_IRQ_EN_BIT];
        end else if (wr_lane && wr_sel == SEL_EN) begin
            loop_irq_enable <= wr.data[IRQ_LOOP_BIT];
        end
    end

    // Bandwidth mode and manual acquisition bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_bw <= BW_RESET[BW_AUTO_BIT];
            acq_manual <= BW_RESET[BW_ACQ_BIT];
        end else if (wr_lane && wr_sel == SEL_BW) begin
            auto_bw <= wr.data[BW_AUTO_BIT];
            if (!auto_bw) begin
                acq_manual <= wr.data[BW_ACQ_BIT];
            end
        end
    end

    // Lock seen only while the loop runs; detect every change
    assign lock_seen = pins_sync.lock && loop_running;
    assign lock_change = lock_seen != lock_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_prev <= 1'b0;
        end else begin
            lock_prev <= lock_seen;
        end
    end

    // Clearing is blocked in break unless break clear is enabled
    assign flag_clear_ok = !break_state || break_flag_clear_enable;
    assign flag_clear = flag_clear_ok && (
        (rd_fire && rd_sel == SEL_CTL) ||
        (wr_lane && wr_sel == SEL_CLR && wr.data[IRQ_LOOP_BIT]));

    // Sticky lock event flag; a new event wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_irq_flag <= CTL_RESET[CTL_FLAG_BIT];
        end else if (auto_bw && lock_change) begin
            loop_irq_flag <= 1'b1;
        end else if (flag_clear) begin
            loop_irq_flag <= 1'b0;
        end
    end

    // Register views
    assign flag_view = loop_irq_flag && auto_bw;
    always_comb begin
        ctl_view = 8'h00;
        ctl_view[CTL_IRQ_EN_BIT] = loop_irq_enable;
        ctl_view[CTL_FLAG_BIT] = flag_view;
        ctl_view[CTL_POWER_BIT] = loop_power_on;
        ctl_view[CTL_SELECT_BIT] = base_clock_select;
        bw_view = 8'h00;
        bw_view[BW_AUTO_BIT] = auto_bw;
        bw_view[BW_LOCK_BIT] = lock_seen && auto_bw;
        bw_view[BW_ACQ_BIT] = auto_bw ? lock_seen : acq_manual;
    end

    // Read data multiplexer; unmapped and write-only read as zero
    always_comb begin
        rd_data = RDATA_RESET;
        case (rd_sel)
            SEL_CTL: rd_data[7:0] = ctl_view;
            SEL_BW: rd_data[7:0] = bw_view;
            SEL_STAT: rd_data[IRQ_LOOP_BIT] = flag_view;
            SEL_EN: rd_data[IRQ_LOOP_BIT] = loop_irq_enable;
            default: rd_data = RDATA_RESET;
        endcase
    end

    // Source edges for the halved core clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vco_prev <= 1'b0;
            xtal_prev <= 1'b0;
        end else begin
            vco_prev <= pins_sync.vco;
            xtal_prev <= pins_sync.xtal;
        end
    end

    assign core_tick = base_clock_select ?
        (loop_running && pins_sync.vco && !vco_prev) :
        (osc_running && pins_sync.xtal && !xtal_prev);

    // Core clock toggles on each rising edge of the selected source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_clock_output <= 1'b0;
        end else if (!osc_running) begin
            core_clock_output <= 1'b0;
        end else if (base_clock_select && !loop_running) begin
            core_clock_output <= 1'b0;
        end else if (core_tick) begin
            core_clock_output <= !core_clock_output;
        end
    end

    // Crystal clock follows the oscillator while it runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crystal_clock <= 1'b0;
        end else begin
            crystal_clock <= osc_running && pins_sync.xtal;
        end
    end

    // Interrupt line, held low in full stop
    assign clockgen_interrupt_line = flag_view && loop_irq_enable
        && osc_running;
endmodule

// ---- sim/loop_model.sv ----
// Behavioural analog side: crystal oscillator, loop oscillator, lock.
// Assumes enables come from the block on aclk; lock_drop from the bench.
`timescale 1ns/1ps
module loop_model #(
    parameter int LOCK_CYC = 40
) (
    input wire logic aclk,
    input wire logic osc_enable,
    input wire logic loop_enable,
    input wire logic lock_drop,
    output logic lock_detect = 1'h0,
    output logic vco_clock = 1'h0,
    output logic crystal_clock_in = 1'h0
);
    int xcnt = 0;
    int vcnt = 0;
    int lcnt = 0;

    // Clocks stand low while their source is disabled
    always @(posedge aclk) begin
        xcnt <= osc_enable ? (xcnt + 1) % 8 : 0;
        crystal_clock_in <= osc_enable && xcnt < 4;
        vcnt <= loop_enable ? (vcnt + 1) % 6 : 0;
        vco_clock <= loop_enable && vcnt < 3;
    end

    // Lock after a settling time; a drop command breaks lock at once
    always @(posedge aclk) begin
        lcnt <= loop_enable ? (lcnt < LOCK_CYC ? lcnt + 1 : lcnt) : 0;
        lock_detect <= loop_enable && lcnt >= LOCK_CYC && !lock_drop;
    end
endmodule

// ---- sim/clkgen_lock_chk.sv ----
// Port-level checker for the clock generator control block.
// Assumes every watched port belongs to aclk; bound below.
`timescale 1ns/1ps
module clkgen_lock_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic lock_detect,
    input wire logic wait_instr,
    input wire logic stop_instr,
    input wire logic osc_keep_in_sleep,
    input wire logic osc_enable,
    input wire logic loop_enable,
    input wire logic crystal_clock,
    input wire logic core_clock_output,
    input wire logic clockgen_interrupt_line
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Stop without keep: enables drop first, registered clocks follow
    sequence s_cut;
        !osc_enable && !loop_enable && !clockgen_interrupt_line;
    endsequence
    sequence s_quiet;
        !crystal_clock && !core_clock_output;
    endsequence

    a_stop_all_off: assert property (
        stop_instr && !osc_keep_in_sleep |=> s_cut ##1 s_quiet)
        else $error("stop left clock generator running");
    a_stop_keep_osc: assert property (
        stop_instr && osc_keep_in_sleep |=> osc_enable && !loop_enable)
        else $error("stop with keep lost oscillator or kept loop");
    a_wait_same: assert property (
        wait_instr && !stop_instr |=>
        osc_enable && loop_enable == $past(loop_enable))
        else $error("wait changed oscillator or loop");
    a_irq_needs_osc: assert property (
        clockgen_interrupt_line |-> osc_enable)
        else $error("interrupt high with oscillator off");
    a_irq_has_cause: assert property (
        $rose(clockgen_interrupt_line) |-> $rose(s_axi_bvalid) ||
        $past(lock_detect, 2) != $past(lock_detect, 5) || !$past(osc_enable))
        else $error("interrupt rose without a cause");
    a_irq_drop_cause: assert property (
        $fell(clockgen_interrupt_line) |->
        $rose(s_axi_rvalid) || $rose(s_axi_bvalid) || !osc_enable)
        else $error("interrupt fell without a cause");
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
endmodule

bind clkgen_lock_ctl clkgen_lock_chk clkgen_lock_chk_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .lock_detect(lock_detect),
    .wait_instr(wait_instr), .stop_instr(stop_instr),
    .osc_keep_in_sleep(osc_keep_in_sleep), .osc_enable(osc_enable),
    .loop_enable(loop_enable), .crystal_clock(crystal_clock),
    .core_clock_output(core_clock_output),
    .clockgen_interrupt_line(clockgen_interrupt_line));

// ---- sim/pll_lock_event_and_power_modes_bench.sv ----
// Self-checking bench for the clock generator control block.
// Assumes loop_model stands in for the analog loop and oscillator.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module pll_lock_event_and_power_modes_bench
    import clkgen_pkg::*;
;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic wait_instr = 1'h0, stop_instr = 1'h0, wake_event = 1'h0;
    logic break_state = 1'h0, break_flag_clear_enable = 1'h0;
    logic osc_keep_in_sleep = 1'h0, lock_drop = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, lock_detect, vco_clock, crystal_clock_in;
    logic osc_enable, loop_enable, crystal_clock, core_clock_output;
    logic clockgen_interrupt_line, core_prev, xtal_prev;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat;
    int fails = 0, checks_done = 0, tog = 0, xtog = 0, t0;

    clkgen_lock_ctl clkgen_lock_ctl_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .lock_detect(lock_detect),
        .vco_clock(vco_clock), .crystal_clock_in(crystal_clock_in),
        .wait_instr(wait_instr), .stop_instr(stop_instr),
        .wake_event(wake_event), .break_state(break_state),
        .break_flag_clear_enable(break_flag_clear_enable),
        .osc_keep_in_sleep(osc_keep_in_sleep), .osc_enable(osc_enable),
        .loop_enable(loop_enable), .crystal_clock(crystal_clock),
        .core_clock_output(core_clock_output),
        .clockgen_interrupt_line(clockgen_interrupt_line));

    loop_model loop_model_inst (.aclk(aclk), .osc_enable(osc_enable),
        .loop_enable(loop_enable), .lock_drop(lock_drop),
        .lock_detect(lock_detect), .vco_clock(vco_clock),
        .crystal_clock_in(crystal_clock_in));

    // 200 MHz clock
    initial forever #2.5 aclk = ~aclk;

    // Edge counters for the divided and crystal outputs
    always @(posedge aclk) begin
        core_prev <= core_clock_output;
        xtal_prev <= crystal_clock;
        tog <= tog + int'(core_clock_output !== core_prev);
        xtog <= xtog + int'(crystal_clock !== xtal_prev);
    end

    // Bus write: address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [2:0] hs;
        bit done;
        done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!done) begin
            @(negedge aclk);
            hs = {s_axi_awvalid & s_axi_awready,
                s_axi_wvalid & s_axi_wready, s_axi_bvalid};
            resp = s_axi_bresp;
            @(posedge aclk);
            if (hs[2]) s_axi_awvalid <= 1'h0;
            if (hs[1]) s_axi_wvalid <= 1'h0;
            if (hs[0]) s_axi_bready <= 1'h0;
            done = hs[0];
        end
    endtask

    // Bus read: data and response taken with rvalid
    task automatic rd(input logic [7:0] a);
        logic [1:0] hs;
        bit done;
        done = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!done) begin
            @(negedge aclk);
            hs = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
            rdat = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (hs[1]) s_axi_arvalid <= 1'h0;
            if (hs[0]) s_axi_rready <= 1'h0;
            done = hs[0];
        end
    endtask

    // Idle, ending mid-cycle so outputs are settled
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask

    // One-cycle mode pulse: 0 wait, 1 stop, 2 wake
    task automatic cmd(input int k);
        @(posedge aclk);
        wait_instr <= k == 0;
        stop_instr <= k == 1;
        wake_event <= k == 2;
        @(posedge aclk);
        {wait_instr, stop_instr, wake_event} <= 3'h0;
    endtask

    task automatic stop_test;
        if (fails == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        #100000;
        fails++;
        stop_test;
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        rd(OFS_CTL);
        `CHK("ctl_reset", CTL_RESET, rdat[7:0])
        rd(OFS_BW);
        `CHK("bw_reset", BW_RESET, rdat[7:0])
        rd(8'h20);
        `CHK("unmapped_resp", RESP_SLVERR, resp)
        `CHK("unmapped_data", RDATA_RESET, rdat)
        wr(8'h20, 32'h0000_00FF);
        `CHK("unmapped_wr", RESP_SLVERR, resp)
        wr(OFS_CTL, 32'h0000_0010);
        rd(OFS_CTL);
        `CHK("sel_guard", 8'h00, rdat[7:0] & 8'h30)
        wr(OFS_CTL, 32'h0000_0020);
        `CHK("wr_okay", RESP_OKAY, resp)
        wr(OFS_CTL, 32'h0000_0030);
        rd(OFS_CTL);
        `CHK("sel_unlocked", 8'h30, rdat[7:0])
        idle(2);
        t0 = tog;
        idle(240);
        `CHK("vco_half", 1'h1, tog - t0 inside {[39:41]})
        wr(OFS_CTL, 32'h0000_0010);
        rd(OFS_CTL);
        `CHK("power_guard", 8'h30, rdat[7:0])
        rd(OFS_BW);
        `CHK("lock_manual", 1'h0, rdat[BW_LOCK_BIT])
        wr(OFS_CTL, 32'h0000_0020);
        idle(2);
        t0 = tog;
        idle(240);
        `CHK("xtal_half", 1'h1, tog - t0 inside {[29:31]})
        wr(OFS_BW, 32'h0000_0080);
        rd(OFS_CTL);
        lock_drop <= 1'h1;
        idle(10);
        `CHK("irq_no_en", 1'h0, clockgen_interrupt_line)
        rd(OFS_IRQ_STAT);
        `CHK("flag_loss", 1'h1, rdat[IRQ_LOOP_BIT])
        rd(OFS_BW);
        `CHK("lock_lost", 1'h0, rdat[BW_LOCK_BIT])
        rd(OFS_CTL);
        `CHK("ctl_flag", 1'h1, rdat[CTL_FLAG_BIT])
        rd(OFS_IRQ_STAT);
        `CHK("read_clear", 1'h0, rdat[IRQ_LOOP_BIT])
        lock_drop <= 1'h0;
        idle(10);
        rd(OFS_IRQ_STAT);
        `CHK("flag_entry", 1'h1, rdat[IRQ_LOOP_BIT])
        wr(OFS_IRQ_EN, 32'h0000_0001);
        idle(1);
        `CHK("irq_en", 1'h1, clockgen_interrupt_line)
        rd(OFS_BW);
        `CHK("lock_auto", 1'h1, rdat[BW_LOCK_BIT])
        wr(OFS_CTL, 32'h0000_00B0);
        wr(OFS_BW, 32'h0000_0000);
        idle(1);
        `CHK("irq_manual", 1'h0, clockgen_interrupt_line)
        rd(OFS_IRQ_STAT);
        `CHK("flag_manual", 1'h0, rdat[IRQ_LOOP_BIT])
        wr(OFS_BW, 32'h0000_0080);
        break_state <= 1'h1;
        rd(OFS_CTL);
        wr(OFS_IRQ_CLR, 32'h0000_0001);
        rd(OFS_IRQ_STAT);
        `CHK("break_keep", 1'h1, rdat[IRQ_LOOP_BIT])
        break_flag_clear_enable <= 1'h1;
        wr(OFS_IRQ_CLR, 32'h0000_0001);
        break_state <= 1'h0;
        rd(OFS_IRQ_STAT);
        `CHK("break_clear", 1'h0, rdat[IRQ_LOOP_BIT])
        lock_drop <= 1'h1;
        idle(10);
        `CHK("irq_set", 1'h1, clockgen_interrupt_line)
        wr(OFS_CTL, 32'h0000_00A0);
        cmd(0);
        idle(2);
        `CHK("wait_osc", 1'h1, osc_enable)
        `CHK("wait_loop", 1'h1, loop_enable)
        cmd(2);
        cmd(1);
        idle(2);
        `CHK("stop_osc", 1'h0, osc_enable)
        `CHK("stop_loop", 1'h0, loop_enable)
        `CHK("stop_irq", 1'h0, clockgen_interrupt_line)
        `CHK("stop_xtal", 1'h0, crystal_clock)
        `CHK("stop_core", 1'h0, core_clock_output)
        cmd(2);
        osc_keep_in_sleep <= 1'h1;
        cmd(1);
        idle(2);
        t0 = xtog;
        idle(40);
        `CHK("keep_osc", 1'h1, osc_enable)
        `CHK("keep_loop", 1'h0, loop_enable)
        `CHK("keep_xtal", 1'h1, xtog - t0 inside {[8:12]})
        cmd(2);
        stop_test;
    end
endmodule
